// [inc/udcrt_pkg.sv]
// Constants shared by the up/down capture and reload timer
package udcrt_pkg;
    // Register port geometry
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int CNT_W = 16;
    localparam int PIN_N = 3;

    // Register offsets
    localparam logic [ADDR_W-1:0] ADDR_CNT_LO = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_CNT_HI = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_RCAP_LO = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_RCAP_HI = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 3'h4;
    localparam logic [ADDR_W-1:0] ADDR_CFG = 3'h5;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 3'h6;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 3'h7;

    // Control register fields
    localparam int CTL_WRAP_BIT = 7;
    localparam int CTL_EXTF_BIT = 6;
    localparam int CTL_EXTEN_BIT = 3;
    localparam int CTL_RUN_BIT = 2;
    localparam int CTL_CSEL_BIT = 1;
    localparam int CTL_CPRL_BIT = 0;
    localparam logic [DATA_W-1:0] CTL_WR_MASK = 8'h0F;

    // Configuration register fields
    localparam int CFG_DCEN_BIT = 0;
    localparam int CFG_CKSEL_LO = 3;
    localparam int CFG_CKSEL_HI = 4;

    // Interrupt status and mask fields
    localparam int IRQ_WRAP_BIT = 0;
    localparam int IRQ_EXT_BIT = 1;
    localparam int IRQ_W = 2;

    // Pin vector positions
    localparam int PIN_COUNT = 0;
    localparam int PIN_CONTROL = 1;
    localparam int PIN_OSC = 2;

    // Reset values and count constants
    localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
    localparam logic [CNT_W-1:0] RCAP_RESET = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;

    // Clock select codes and their division counts
    localparam logic [1:0] CKSEL_SYS = 2'h0;
    localparam logic [1:0] CKSEL_DIV2 = 2'h1;
    localparam logic [1:0] CKSEL_DIV12 = 2'h2;
    localparam logic [1:0] CKSEL_EXT8 = 2'h3;
    localparam logic [3:0] DIV_SYS = 4'h1;
    localparam logic [3:0] DIV_TWO = 4'h2;
    localparam logic [3:0] DIV_TWELVE = 4'hC;
    localparam logic [3:0] DIV_EXT = 4'h8;
    localparam logic [3:0] DIV_CNT_ONE = 4'h1;
    localparam logic [3:0] DIV_CNT_ZERO = 4'h0;

    typedef logic [DATA_W-1:0] udcrt_byte_t;
endpackage : udcrt_pkg

// [src/udcrt_edge_sync.sv]
// Two-stage pin synchroniser with edge detection
`timescale 1ns/1ps
module udcrt_edge_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pin side
    input wire logic pinRaw,
    // Synchronised results
    output logic pinLevel,
    output logic pinFall,
    output logic pinRise
);
    logic syncA_r;
    logic syncB_r;
    logic prev_r;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            syncA_r <= 1'b0;
            syncB_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            syncA_r <= pinRaw;
            syncB_r <= syncA_r;
            prev_r <= syncB_r;
        end
    end

    assign pinLevel = syncB_r;
    // One pulse per detected transition
    assign pinFall = prev_r & ~syncB_r;
    assign pinRise = ~prev_r & syncB_r;
endmodule : udcrt_edge_sync

// [src/udcrt_prescale.sv]
// Timer clock prescaler producing a one-cycle count tick
`timescale 1ns/1ps
module udcrt_prescale (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Selection and external oscillator edges
    input wire logic [1:0] clkSel,
    input wire logic oscRise,
    // Count tick
    output logic tick
);
    import udcrt_pkg::*;

    logic [3:0] divCnt_r;
    logic tick_r;
    logic srcPulse;
    logic lastStep;

    function automatic logic [3:0] divLimit(input logic [1:0] sel);
        case (sel)
            CKSEL_SYS: divLimit = DIV_SYS;
            CKSEL_DIV2: divLimit = DIV_TWO;
            CKSEL_DIV12: divLimit = DIV_TWELVE;
            default: divLimit = DIV_EXT;
        endcase
    endfunction : divLimit

    assign srcPulse = (clkSel == CKSEL_EXT8) ? oscRise : 1'b1;
    // A select change can leave the count above the new limit; >= recovers at once
    assign lastStep = divCnt_r >= (divLimit(clkSel) - DIV_CNT_ONE);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            divCnt_r <= DIV_CNT_ZERO;
        end else if (srcPulse) begin
            divCnt_r <= lastStep ? DIV_CNT_ZERO : divCnt_r + DIV_CNT_ONE;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_r <= 1'b0;
        end else begin
            tick_r <= srcPulse & lastStep;
        end
    end

    assign tick = tick_r;
endmodule : udcrt_prescale

// [src/udcrt_timer.sv]
// 16-bit up/down counter/timer with capture and auto-reload modes
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
// Summary of operation
// - Count is two software-accessible bytes
// - Clock select: system_clock, /2, /12, oscillator /8
// - Counter select picks count-pin falling edges
// - Decrement enable: control pin sets direction
// - Decrement enable blocks control-pin capture/reload
// - Control-pin fall captures count when enabled
// - Capture sets external flag and interrupt
// - Capture mode overflow sets wrap flag
// - Capture mode down count wraps 0000 to FFFF, flags
// - External enable clear ignores control-pin falls
// - Run bit enables counting; reload default
// - Reload up overflow loads capture value
// - Control-pin fall forces reload when enabled
// - Reload down match loads FFFF, flags
// - Reload mode toggles external flag, no interrupt
// - Wrap events offered to converter triggers
module udcrt_timer #(
    parameter bit ADC_TRIGGER_EN = 1'b1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [udcrt_pkg::ADDR_W-1:0] regAddr,
    input wire logic [udcrt_pkg::DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [udcrt_pkg::DATA_W-1:0] regRdData,
    // External pins and oscillator
    input wire logic extCountPin,
    input wire logic extControlPin,
    input wire logic extOscClk,
    // Interrupt and event outputs
    output logic irq,
    output logic adcStartPulse,
    output logic dacUpdatePulse
);
    import udcrt_pkg::*;

    // Software-visible state
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic [CNT_W-1:0] rcap_r;
    logic [CNT_W-1:0] rcap_nxt;
    logic wrapFlag_r;
    logic extFlag_r;
    logic extEdgeEnable_r;
    logic runControl_r;
    logic counterSelect_r;
    logic captureReloadSel_r;
    logic decrementEnable_r;
    logic [1:0] clockSelect_r;
    logic [IRQ_W-1:0] irqStat_r;
    logic [IRQ_W-1:0] irqMask_r;
    udcrt_byte_t rdData_r;
    logic irq_r;
    logic adcStart_r;
    logic dacUpdate_r;

    // Pin synchronisers
    logic [PIN_N-1:0] pinRawVec;
    logic [PIN_N-1:0] pinLevelVec;
    logic [PIN_N-1:0] pinFallVec;
    logic [PIN_N-1:0] pinRiseVec;

    // Event decode
    logic timerTick;
    logic countEvent;
    logic countUp;
    logic extEdge;
    logic captureEvt;
    logic reloadEvt;
    logic wrapEvt;
    logic toggleEvt;
    logic extIrqEvt;
    udcrt_byte_t ctrlView;
    udcrt_byte_t cfgView;
    udcrt_byte_t rdMux;

    function automatic logic regHit(input logic strobe, input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] target);
        regHit = strobe & (addr == target);
    endfunction : regHit

    assign pinRawVec[PIN_COUNT] = extCountPin;
    assign pinRawVec[PIN_CONTROL] = extControlPin;
    assign pinRawVec[PIN_OSC] = extOscClk;

    generate
        for (genvar p = 0; p < PIN_N; p++) begin : g_pin
            udcrt_edge_sync u_sync (
                .clk(clk),
                .rst_n(rst_n),
                .pinRaw(pinRawVec[p]),
                .pinLevel(pinLevelVec[p]),
                .pinFall(pinFallVec[p]),
                .pinRise(pinRiseVec[p])
            );
        end
    endgenerate

    udcrt_prescale u_prescale (
        .clk(clk),
        .rst_n(rst_n),
        .clkSel(clockSelect_r),
        .oscRise(pinRiseVec[PIN_OSC]),
        .tick(timerTick)
    );

    // Count source and direction
    assign countEvent = runControl_r
        & (counterSelect_r ? pinFallVec[PIN_COUNT] : timerTick);
    assign countUp = ~decrementEnable_r | pinLevelVec[PIN_CONTROL];
    // Direction use takes the control pin away from capture and reload
    assign extEdge = pinFallVec[PIN_CONTROL] & extEdgeEnable_r
        & ~decrementEnable_r;
    assign captureEvt = extEdge & captureReloadSel_r;
    assign reloadEvt = extEdge & ~captureReloadSel_r;

    // Wrap detection per mode
    always_comb begin
        wrapEvt = 1'b0;
        if (countEvent) begin
            if (countUp) begin
                wrapEvt = (count_r == CNT_MAX);
            end else if (captureReloadSel_r) begin
                wrapEvt = (count_r == CNT_ZERO);
            end else begin
                wrapEvt = (count_r == rcap_r);
            end
        end
    end

    // A forced reload in the same cycle replaces the wrap's toggle; it flags on its own
    assign toggleEvt = wrapEvt & ~captureReloadSel_r & ~reloadEvt;
    assign extIrqEvt = captureEvt | reloadEvt;

    // Count register: software write wins over counting
    always_comb begin
        count_nxt = count_r;
        if (reloadEvt) begin
            count_nxt = rcap_r;
        end else if (countEvent) begin
            if (countUp) begin
                if (wrapEvt && !captureReloadSel_r) begin
                    count_nxt = rcap_r;
                end else begin
                    count_nxt = count_r + CNT_ONE;
                end
            end else begin
                if (wrapEvt && !captureReloadSel_r) begin
                    count_nxt = CNT_MAX;
                end else begin
                    count_nxt = count_r - CNT_ONE;
                end
            end
        end
        if (regHit(regWr, regAddr, ADDR_CNT_LO)) begin
            count_nxt[7:0] = regWrData;
        end
        if (regHit(regWr, regAddr, ADDR_CNT_HI)) begin
            count_nxt[15:8] = regWrData;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= CNT_RESET;
        end else begin
            count_r <= count_nxt;
        end
    end

    // Capture/reload register: a capture wins over a software write
    always_comb begin
        rcap_nxt = rcap_r;
        if (regHit(regWr, regAddr, ADDR_RCAP_LO)) begin
            rcap_nxt[7:0] = regWrData;
        end
        if (regHit(regWr, regAddr, ADDR_RCAP_HI)) begin
            rcap_nxt[15:8] = regWrData;
        end
        if (captureEvt) begin
            rcap_nxt = count_r;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rcap_r <= RCAP_RESET;
        end else begin
            rcap_r <= rcap_nxt;
        end
    end

    // Wrap flag: hardware set wins over a software clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrapFlag_r <= 1'b0;
        end else if (wrapEvt) begin
            wrapFlag_r <= 1'b1;
        end else if (regHit(regWr, regAddr, ADDR_CTRL)) begin
            wrapFlag_r <= regWrData[CTL_WRAP_BIT];
        end
    end

    // External flag: set by capture or reload, toggled by reload-mode wraps
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            extFlag_r <= 1'b0;
        end else if (extIrqEvt) begin
            extFlag_r <= 1'b1;
        end else if (toggleEvt) begin
            extFlag_r <= ~extFlag_r;
        end else if (regHit(regWr, regAddr, ADDR_CTRL)) begin
            extFlag_r <= regWrData[CTL_EXTF_BIT];
        end
    end

    // Control bits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            extEdgeEnable_r <= 1'b0;
            runControl_r <= 1'b0;
            counterSelect_r <= 1'b0;
            captureReloadSel_r <= 1'b0;
        end else if (regHit(regWr, regAddr, ADDR_CTRL)) begin
            extEdgeEnable_r <= regWrData[CTL_EXTEN_BIT];
            runControl_r <= regWrData[CTL_RUN_BIT];
            counterSelect_r <= regWrData[CTL_CSEL_BIT];
            captureReloadSel_r <= regWrData[CTL_CPRL_BIT];
        end
    end

    // Configuration bits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            decrementEnable_r <= 1'b0;
            clockSelect_r <= CKSEL_SYS;
        end else if (regHit(regWr, regAddr, ADDR_CFG)) begin
            decrementEnable_r <= regWrData[CFG_DCEN_BIT];
            clockSelect_r <= regWrData[CFG_CKSEL_HI:CFG_CKSEL_LO];
        end
    end

    // Interrupt status: sticky, cleared by reading; a new event wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irqStat_r <= '0;
        end else begin
            if (wrapEvt) begin
                irqStat_r[IRQ_WRAP_BIT] <= 1'b1;
            end else if (regHit(regRd, regAddr, ADDR_IRQ_STAT)) begin
                irqStat_r[IRQ_WRAP_BIT] <= 1'b0;
            end
            // Reload-mode toggles of the external flag raise no interrupt
            if (extIrqEvt) begin
                irqStat_r[IRQ_EXT_BIT] <= 1'b1;
            end else if (regHit(regRd, regAddr, ADDR_IRQ_STAT)) begin
                irqStat_r[IRQ_EXT_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irqMask_r <= '0;
        end else if (regHit(regWr, regAddr, ADDR_IRQ_MASK)) begin
            irqMask_r <= regWrData[IRQ_W-1:0];
        end
    end

    // Level interrupt, one cycle behind the status it reflects
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(irqStat_r & irqMask_r);
        end
    end

    // Converter triggers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            adcStart_r <= 1'b0;
            dacUpdate_r <= 1'b0;
        end else begin
            adcStart_r <= wrapEvt & ADC_TRIGGER_EN;
            dacUpdate_r <= wrapEvt;
        end
    end

    // Register read views; reserved bits read as zero
    always_comb begin
        ctrlView = BYTE_ZERO;
        ctrlView[CTL_WRAP_BIT] = wrapFlag_r;
        ctrlView[CTL_EXTF_BIT] = extFlag_r;
        ctrlView[CTL_EXTEN_BIT] = extEdgeEnable_r;
        ctrlView[CTL_RUN_BIT] = runControl_r;
        ctrlView[CTL_CSEL_BIT] = counterSelect_r;
        ctrlView[CTL_CPRL_BIT] = captureReloadSel_r;
        cfgView = BYTE_ZERO;
        cfgView[CFG_DCEN_BIT] = decrementEnable_r;
        cfgView[CFG_CKSEL_HI:CFG_CKSEL_LO] = clockSelect_r;
    end

    always_comb begin
        rdMux = BYTE_ZERO;
        case (regAddr)
            ADDR_CNT_LO: rdMux = count_r[7:0];
            ADDR_CNT_HI: rdMux = count_r[15:8];
            ADDR_RCAP_LO: rdMux = rcap_r[7:0];
            ADDR_RCAP_HI: rdMux = rcap_r[15:8];
            ADDR_CTRL: rdMux = ctrlView;
            ADDR_CFG: rdMux = cfgView;
            ADDR_IRQ_STAT: rdMux = {{(DATA_W-IRQ_W){1'b0}}, irqStat_r};
            ADDR_IRQ_MASK: rdMux = {{(DATA_W-IRQ_W){1'b0}}, irqMask_r};
            default: rdMux = BYTE_ZERO;
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData_r <= BYTE_ZERO;
        end else if (regRd) begin
            rdData_r <= rdMux;
        end else begin
            rdData_r <= BYTE_ZERO;
        end
    end

    assign regRdData = rdData_r;
    assign irq = irq_r;
    assign adcStartPulse = adcStart_r;
    assign dacUpdatePulse = dacUpdate_r;
endmodule : udcrt_timer

// [test/udcrt_asserts.sv]
// Port checker for the up/down capture and reload timer
`timescale 1ns/1ps
module udcrt_asserts #(
    parameter bit ADC_TRIGGER_EN = 1'b1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [udcrt_pkg::ADDR_W-1:0] regAddr,
    input wire logic [udcrt_pkg::DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [udcrt_pkg::DATA_W-1:0] regRdData,
    // Pins and events
    input wire logic extCountPin,
    input wire logic extControlPin,
    input wire logic extOscClk,
    input wire logic irq,
    input wire logic adcStartPulse,
    input wire logic dacUpdatePulse
);
    import udcrt_pkg::*;
    // Software-written copies, so readback can be judged without the bodies
    logic [7:0] ctl_r;
    logic [7:0] cfg_r;
    logic [7:0] msk_r;
    logic runSh;
    assign runSh = ctl_r[CTL_RUN_BIT];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_r <= BYTE_ZERO;
            cfg_r <= BYTE_ZERO;
            msk_r <= BYTE_ZERO;
        end else if (regWr) begin
            if (regAddr == ADDR_CTRL) ctl_r <= regWrData;
            if (regAddr == ADDR_CFG) cfg_r <= regWrData;
            if (regAddr == ADDR_IRQ_MASK) msk_r <= regWrData;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_RD_IDLE: assert property (!$past(regRd) |-> regRdData == BYTE_ZERO)
        else $error("read data not zero outside the read slot");
    AST_CFG_RB: assert property ($past(regRd && regAddr == ADDR_CFG)
        |-> regRdData == (cfg_r & 8'h19))
        else $error("config readback wrong");
    AST_CTL_RB: assert property ($past(regRd && regAddr == ADDR_CTRL)
        |-> regRdData[3:0] == ctl_r[3:0] && regRdData[5:4] == 2'h0)
        else $error("control readback wrong");
    AST_MSK_RB: assert property ($past(regRd && regAddr == ADDR_IRQ_MASK)
        |-> regRdData == (msk_r & 8'h03))
        else $error("mask readback wrong");
    AST_IRQ_OFF: assert property (msk_r == BYTE_ZERO && $past(msk_r) == BYTE_ZERO |-> !irq)
        else $error("interrupt with all sources masked");
    AST_IRQ_WRAP: assert property (dacUpdatePulse && msk_r[IRQ_WRAP_BIT] && $stable(msk_r)
        |-> ##[0:1] irq)
        else $error("wrap event without interrupt");
    AST_ADC_DAC: assert property (adcStartPulse == (dacUpdatePulse && ADC_TRIGGER_EN))
        else $error("converter trigger differs from wrap event");
    AST_RUN_STOP: assert property (!runSh && !$past(runSh) && !$past(runSh, 2)
        |-> !dacUpdatePulse)
        else $error("wrap event while stopped");
endmodule : udcrt_asserts

bind udcrt_timer udcrt_asserts #(.ADC_TRIGGER_EN(ADC_TRIGGER_EN)) chk_u (.clk(clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .extCountPin(extCountPin), .extControlPin(extControlPin),
    .extOscClk(extOscClk), .irq(irq), .adcStartPulse(adcStartPulse),
    .dacUpdatePulse(dacUpdatePulse));

// [test/udcrt_pin_model.sv]
// Model of the external count, control and oscillator pins
`timescale 1ns/1ps
module udcrt_pin_model (
    // Clock
    input wire logic clk,
    // Pins toward the timer
    output logic countPin,
    output logic controlPin,
    output logic oscClk
);
    initial begin
        countPin = 1'b1;
        controlPin = 1'b1;
        oscClk = 1'b0;
        // Free-running, phase unrelated to clk
        forever #230 oscClk = ~oscClk;
    end
    // Levels held three clocks or more so the synchroniser sees each one
    task automatic countFalls(input int n);
        repeat (n) begin
            @(posedge clk);
            countPin <= 1'b0;
            repeat (3) @(posedge clk);
            countPin <= 1'b1;
            repeat (3) @(posedge clk);
        end
    endtask : countFalls
    task automatic setControl(input logic v);
        @(posedge clk);
        controlPin <= v;
        repeat (4) @(posedge clk);
    endtask : setControl
endmodule : udcrt_pin_model

// [test/tb.sv]
// Self-checking testbench for the up/down capture and reload timer
`timescale 1ns/1ps
module tb;
    import udcrt_pkg::*;
    logic clk, rst_n, regWr, regRd, irq, adcStartPulse, dacUpdatePulse;
    logic cntPin, ctlPin, osc, rdSeen;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWrData, regRdData;
    logic [31:0] rngState;
    int errCount, samplesChecked;
    logic [7:0] wrapCnt = 8'h00, adcCnt = 8'h00;
    logic [7:0] expQ[$];
    int tolQ[$];
    string nameQ[$];
    localparam logic [7:0] TICKS [4] = '{8'h62, 8'h31, 8'h08, 8'h03};

    udcrt_timer #(.ADC_TRIGGER_EN(1'b1)) dut_u (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .extCountPin(cntPin), .extControlPin(ctlPin), .extOscClk(osc), .irq(irq),
        .adcStartPulse(adcStartPulse), .dacUpdatePulse(dacUpdatePulse));
    udcrt_pin_model pm_u (.clk(clk), .countPin(cntPin), .controlPin(ctlPin), .oscClk(osc));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errCount++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Read data arrive one cycle after the strobe; oldest note is compared
    always @(posedge clk) begin : monitor
        logic [7:0] e;
        logic [7:0] d;
        if (rdSeen === 1'b1) begin
            e = expQ.pop_front();
            d = (regRdData > e) ? regRdData - e : e - regRdData;
            chk(nameQ.pop_front(), (d <= tolQ.pop_front()) ? e : regRdData, e);
        end
        rdSeen <= regRd;
        // Converter triggers are tallied and judged once all wraps are done
        if (dacUpdatePulse === 1'b1) wrapCnt <= wrapCnt + 8'h01;
        if (adcStartPulse === 1'b1) adcCnt <= adcCnt + 8'h01;
    end

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [7:0] x, input string nm, input int t = 0);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        expQ.push_back(x);
        nameQ.push_back(nm);
        tolQ.push_back(t);
        @(posedge clk);
        regRd <= 1'b0;
    endtask : rd

    task automatic wr16(input logic [2:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a + 3'h1, v[15:8]);
    endtask : wr16

    task automatic rd16(input logic [2:0] a, input logic [15:0] v, input string nm);
        rd(a, v[7:0], nm);
        rd(a + 3'h1, v[15:8], nm);
    endtask : rd16

    task automatic chkIrq(input logic v);
        @(negedge clk);
        chk("irq", {7'h00, irq}, {7'h00, v});
    endtask : chkIrq

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic conclude();
        $display("checks %0d mismatches %0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude

    initial begin
        #1_000_000;
        errCount++;
        conclude();
    end

    initial begin : main
        rst_n = 1'b0;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 3'h0;
        regWrData = 8'h00;
        rdSeen = 1'b0;
        errCount = 0;
        samplesChecked = 0;
        rngState = 32'h0000_02E3;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 8; a++) rd(a[2:0], BYTE_ZERO, "reset");
        repeat (3) begin
            rngState = xs(rngState);
            wr16(ADDR_CNT_LO, rngState[15:0]);
            wr16(ADDR_RCAP_LO, rngState[31:16]);
            rd16(ADDR_CNT_LO, rngState[15:0], "count");
            rd16(ADDR_RCAP_LO, rngState[31:16], "rcap");
        end
        wr(ADDR_CFG, 8'hFF);
        rd(ADDR_CFG, 8'h19, "cfg");
        wr(ADDR_CFG, 8'h00);
        $display("test registers finished");
        // Capture mode, counting count-pin falls upward through the wrap
        wr(ADDR_CTRL, 8'h0F);
        wr16(ADDR_CNT_LO, 16'hFFFE);
        pm_u.countFalls(2);
        rd16(ADDR_CNT_LO, 16'h0000, "wrapUp");
        rd(ADDR_CTRL, 8'h8F, "wrapFlag");
        chkIrq(1'b0);
        wr(ADDR_IRQ_MASK, 8'hFF);
        rd(ADDR_IRQ_MASK, 8'h03, "mask");
        chkIrq(1'b1);
        rd(ADDR_IRQ_STAT, 8'h01, "statWrap");
        repeat (2) @(posedge clk);
        chkIrq(1'b0);
        rd(ADDR_CTRL, 8'h8F, "flagHold");
        wr(ADDR_CTRL, 8'h0F);
        wr16(ADDR_CNT_LO, 16'hA5C3);
        pm_u.setControl(1'b0);
        pm_u.setControl(1'b1);
        rd16(ADDR_RCAP_LO, 16'hA5C3, "capture");
        rd(ADDR_CTRL, 8'h4F, "extFlag");
        chkIrq(1'b1);
        rd(ADDR_IRQ_STAT, 8'h02, "statExt");
        $display("test capture finished");
        // External enable clear: no capture
        wr(ADDR_CTRL, 8'h07);
        wr16(ADDR_CNT_LO, 16'h0000);
        pm_u.setControl(1'b0);
        pm_u.setControl(1'b1);
        rd16(ADDR_RCAP_LO, 16'hA5C3, "noCapture");
        rd(ADDR_CTRL, 8'h07, "noExtFlag");
        // Decrement enabled: control pin steers, never captures
        wr(ADDR_CTRL, 8'h0F);
        wr(ADDR_CFG, 8'h01);
        pm_u.setControl(1'b0);
        pm_u.countFalls(1);
        rd16(ADDR_CNT_LO, 16'hFFFF, "down");
        rd16(ADDR_RCAP_LO, 16'hA5C3, "dirOnly");
        rd(ADDR_CTRL, 8'h8F, "downFlags");
        pm_u.setControl(1'b1);
        pm_u.countFalls(1);
        rd16(ADDR_CNT_LO, 16'h0000, "dirUp");
        $display("test direction finished");
        // Reload mode up, forced reload, down
        wr(ADDR_CFG, 8'h00);
        wr(ADDR_CTRL, 8'h06);
        wr16(ADDR_RCAP_LO, 16'h1234);
        wr16(ADDR_CNT_LO, 16'hFFFF);
        rd(ADDR_IRQ_STAT, 8'h01, "statOld");
        pm_u.countFalls(1);
        rd16(ADDR_CNT_LO, 16'h1234, "reloadUp");
        rd(ADDR_CTRL, 8'hC6, "toggle");
        rd(ADDR_IRQ_STAT, 8'h01, "noExtIrq");
        wr(ADDR_CTRL, 8'h0E);
        wr16(ADDR_CNT_LO, 16'h5555);
        pm_u.setControl(1'b0);
        pm_u.setControl(1'b1);
        rd16(ADDR_CNT_LO, 16'h1234, "forced");
        rd(ADDR_CTRL, 8'h4E, "forcedFlag");
        rd(ADDR_IRQ_STAT, 8'h02, "forcedStat");
        wr(ADDR_CTRL, 8'h06);
        wr(ADDR_CFG, 8'h01);
        pm_u.setControl(1'b0);
        wr16(ADDR_RCAP_LO, 16'h0010);
        wr16(ADDR_CNT_LO, 16'h0011);
        pm_u.countFalls(2);
        rd16(ADDR_CNT_LO, 16'hFFFF, "reloadDown");
        rd(ADDR_CTRL, 8'hC6, "downToggle");
        pm_u.setControl(1'b1);
        $display("test reload finished");
        // Stopped counter ignores count pin
        wr(ADDR_CFG, 8'h00);
        wr(ADDR_CTRL, 8'h02);
        wr16(ADDR_CNT_LO, 16'h0000);
        pm_u.countFalls(2);
        rd16(ADDR_CNT_LO, 16'h0000, "stopped");
        // Clock selects over a fixed run window
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_CFG, 8'(k << 3));
            wr16(ADDR_CNT_LO, 16'h0000);
            wr(ADDR_CTRL, 8'h04);
            repeat (96) @(posedge clk);
            wr(ADDR_CTRL, 8'h00);
            rd(ADDR_CNT_LO, TICKS[k], "ticks", 2);
        end
        $display("test clocks finished");
        repeat (3) @(posedge clk);
        // Five wraps: capture up, capture down, capture up, reload up, reload down
        chk("wraps", wrapCnt, 8'h05);
        chk("adcStarts", adcCnt, 8'h05);
        conclude();
    end
endmodule : tb
